// file: cct_regs.sv
// counter/capture register tail: run status, debug halt, staging byte, count and capture/compare
`timescale 1ns/100ps
`include "cct_defines.svh"
module cct_regs (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            reset_n,
  // register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  // counter engine side
  input  wire cct_pkg::cct_mode_t mode,
  input  wire logic            enable,
  input  wire logic            capture_event,
  input  wire logic            cpu_halted,
  input  wire logic            flag_clear,
  output logic                 capture_flag,
  output logic                 running,
  output logic      [15:0]     counter_out
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [7:0]  staging_q, staging_d;
  logic        keep_q, keep_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] capture_compare_value_q, capture_compare_value_d;
  logic        flag_q, flag_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        run_q, run_d;
  cct_pkg::cct_stage_t stage_q, stage_d;

  // capture modes share the capture/compare as a holding register
  function automatic logic is_capture(input cct_pkg::cct_mode_t m);
    is_capture = (m == cct_pkg::CCT_MODE_CAPTURE_FLAG_EVT) || (m == cct_pkg::CCT_MODE_CAPTURE_FLAG_FRQ) ||
                 (m == cct_pkg::CCT_MODE_CAPTURE_FLAG_PW) || (m == cct_pkg::CCT_MODE_CAPTURE_FLAG_FPW);
  endfunction : is_capture

  // address hit helper, used for the flags and capture/compare low byte checks
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  // -------------------------------------------------------------
  // counter engine and register next values
  // -------------------------------------------------------------
  logic        active;
  logic [15:0] top;
  logic        at_top;
  logic        hw_cnt_upd;
  logic [15:0] hw_cnt_val;

  // debug halt freezes counting and drops events unless keep-going is set
  always_comb begin
    active = enable && (keep_q || !cpu_halted);
    top    = (mode == cct_pkg::CCT_MODE_PWM8) ? {8'h00, capture_compare_value_q[7:0]} : capture_compare_value_q;
    at_top = (cnt_q == top);
    hw_cnt_upd = active;
    hw_cnt_val = cnt_q + 16'h0001;
    if (is_capture(mode)) begin
      if (capture_event && (mode == cct_pkg::CCT_MODE_CAPTURE_FLAG_FRQ)) begin
        hw_cnt_val = `CCT_RST_WORD;
      end
    end else if (at_top) begin
      hw_cnt_val = `CCT_RST_WORD;
    end
  end

  always_comb begin
    staging_d = staging_q;
    keep_d    = keep_q;
    cnt_d     = cnt_q;
    capture_compare_value_d    = capture_compare_value_q;
    flag_d    = flag_q;
    stage_d   = stage_q;
    rdata_d   = rdata_q;
    run_d     = active;
    // hardware updates first, bus writes override below
    if (hw_cnt_upd) begin
      cnt_d = hw_cnt_val;
    end
    if (active && is_capture(mode) && capture_event) begin
      capture_compare_value_d = cnt_q;
    end
    // bus reads
    if (reg_rd) begin
      case (reg_addr)
        `CCT_OFF_RUN_STATE: rdata_d = {7'h00, run_q};
        `CCT_OFF_DEBUG:     rdata_d = {7'h00, keep_q};
        `CCT_OFF_STAGING:   rdata_d = staging_q;
        `CCT_OFF_CNT_LO: begin
          rdata_d   = cnt_q[7:0];
          staging_d = cnt_q[15:8];
        end
        `CCT_OFF_CAPTURE_COMPARE_VALUE_LO: begin
          rdata_d   = capture_compare_value_q[7:0];
          staging_d = capture_compare_value_q[15:8];
        end
        `CCT_OFF_CNT_HI, `CCT_OFF_CAPTURE_COMPARE_VALUE_HI: rdata_d = staging_q;
        default: rdata_d = 8'h00;
      endcase
      if (hit(reg_addr, `CCT_OFF_CAPTURE_COMPARE_VALUE_LO) && is_capture(mode)) begin
        flag_d = 1'b0;
      end
    end
    // bus writes; the run bit has no write path
    if (reg_wr) begin
      case (reg_addr)
        `CCT_OFF_DEBUG:   keep_d = reg_wdata[`CCT_BIT_KEEP];
        `CCT_OFF_STAGING: staging_d = reg_wdata;
        `CCT_OFF_CNT_LO, `CCT_OFF_CAPTURE_COMPARE_VALUE_LO: begin
          staging_d = reg_wdata;
          stage_d   = cct_pkg::CCT_ST_HELD;
        end
        `CCT_OFF_CNT_HI: begin
          cnt_d   = {reg_wdata, staging_q};
          stage_d = cct_pkg::CCT_ST_IDLE;
        end
        `CCT_OFF_CAPTURE_COMPARE_VALUE_HI: begin
          capture_compare_value_d  = {reg_wdata, staging_q};
          stage_d = cct_pkg::CCT_ST_IDLE;
        end
        default: begin
        end
      endcase
      if (hit(reg_addr, `CCT_OFF_FLAGS) && reg_wdata[0]) begin
        flag_d = 1'b0;
      end
    end
    if (flag_clear) begin
      flag_d = 1'b0;
    end
    // set wins over any clear in the same cycle
    if (active && is_capture(mode) && capture_event) begin
      flag_d = 1'b1;
    end
    if (active && (mode == cct_pkg::CCT_MODE_PWM8) && (cnt_q[7:0] == capture_compare_value_q[15:8])) begin
      flag_d = 1'b1;
    end
    if (active && !is_capture(mode) && (mode != cct_pkg::CCT_MODE_PWM8) && at_top) begin
      flag_d = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      staging_q <= `CCT_RST_BYTE;
      keep_q    <= 1'b0;
      cnt_q     <= `CCT_RST_WORD;
      capture_compare_value_q    <= `CCT_RST_WORD;
      flag_q    <= 1'b0;
      rdata_q   <= `CCT_RST_BYTE;
      run_q     <= 1'b0;
      stage_q   <= cct_pkg::CCT_ST_IDLE;
    end else begin
      staging_q <= staging_d;
      keep_q    <= keep_d;
      cnt_q     <= cnt_d;
      capture_compare_value_q    <= capture_compare_value_d;
      flag_q    <= flag_d;
      rdata_q   <= rdata_d;
      run_q     <= run_d;
      stage_q   <= stage_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata    = rdata_q;
  assign capture_flag = flag_q;
  assign running      = run_q;
  assign counter_out  = cnt_q;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_run_tracks;
    @(posedge clock) disable iff (!reset_n) 1'b1 |=> (run_q == $past(active));
  endproperty
  a_run_tracks: assert property (p_run_tracks) else $error("run bit wrong");

  property p_run_ro;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == `CCT_OFF_RUN_STATE && !active) |=> !run_q;
  endproperty
  a_run_ro: assert property (p_run_ro) else $error("run bit written");

  property p_halt_freeze;
    @(posedge clock) disable iff (!reset_n)
      (cpu_halted && !keep_q && !reg_wr) |=> $stable(cnt_q);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in halt");

  property p_halt_run;
    @(posedge clock) disable iff (!reset_n)
      (cpu_halted && keep_q && enable && !reg_wr && !at_top && !is_capture(mode))
      |=> (cnt_q == $past(cnt_q) + 16'h0001);
  endproperty
  a_halt_run: assert property (p_halt_run) else $error("counter stalled in halt");

  property p_write_wins;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == `CCT_OFF_CNT_HI) |=> (cnt_q == {$past(reg_wdata), $past(staging_q)});
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to update");

  property p_low_latch;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && !reg_wr && reg_addr == `CCT_OFF_CNT_LO) |=> (staging_q == $past(cnt_q[15:8]));
  endproperty
  a_low_latch: assert property (p_low_latch) else $error("high byte not staged");

  property p_capture_load;
    @(posedge clock) disable iff (!reset_n)
      (active && is_capture(mode) && capture_event && !reg_wr) |=> (capture_compare_value_q == $past(cnt_q));
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture not loaded");

  property p_read_clear;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == `CCT_OFF_CAPTURE_COMPARE_VALUE_LO && is_capture(mode) && !capture_event) |=> !flag_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

  property p_pwm_flag;
    @(posedge clock) disable iff (!reset_n)
      (active && mode == cct_pkg::CCT_MODE_PWM8 && cnt_q[7:0] == capture_compare_value_q[15:8]) |=> flag_q;
  endproperty
  a_pwm_flag: assert property (p_pwm_flag) else $error("duty match missed");

  // reset leaves count, capture/compare and flag at zero
  property p_reset_zero;
    @(posedge clock)
      !reset_n |=> (cnt_q == `CCT_RST_WORD && capture_compare_value_q == `CCT_RST_WORD && !flag_q);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  // a low-byte write parks in staging and marks the pair as half done
  property p_stage_held;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && (reg_addr == `CCT_OFF_CNT_LO || reg_addr == `CCT_OFF_CAPTURE_COMPARE_VALUE_LO))
      |=> (stage_q == cct_pkg::CCT_ST_HELD && staging_q == $past(reg_wdata));
  endproperty
  a_stage_held: assert property (p_stage_held) else $error("low write not staged");

  // high-byte write commits both bytes, even against a capture
  property p_capture_compare_value_write;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == `CCT_OFF_CAPTURE_COMPARE_VALUE_HI) |=> (capture_compare_value_q == {$past(reg_wdata), $past(staging_q)});
  endproperty
  a_capture_compare_value_write: assert property (p_capture_compare_value_write) else $error("compare write lost");

  // compare acts as top: the count wraps to zero and flags
  property p_top_wrap;
    @(posedge clock) disable iff (!reset_n)
      (active && !reg_wr && cnt_q == capture_compare_value_q && (mode == cct_pkg::CCT_MODE_PERIODIC ||
       mode == cct_pkg::CCT_MODE_TIMEOUT || mode == cct_pkg::CCT_MODE_SINGLE)) |=> (cnt_q == 16'h0000 && flag_q);
  endproperty
  a_top_wrap: assert property (p_top_wrap) else $error("top not honoured");

  // in pwm8 only the period byte bounds the count
  property p_pwm_period;
    @(posedge clock) disable iff (!reset_n)
      (active && !reg_wr && mode == cct_pkg::CCT_MODE_PWM8 && cnt_q == {8'h00, capture_compare_value_q[7:0]})
      |=> (cnt_q == 16'h0000);
  endproperty
  a_pwm_period: assert property (p_pwm_period) else $error("period byte ignored");

  // frequency capture restarts the count from zero on the event
  property p_freq_restart;
    @(posedge clock) disable iff (!reset_n)
      (active && mode == cct_pkg::CCT_MODE_CAPTURE_FLAG_FRQ && capture_event && !reg_wr) |=> (cnt_q == 16'h0000);
  endproperty
  a_freq_restart: assert property (p_freq_restart) else $error("no restart on capture");

  // writing one to the flag bit clears it when no event competes
  property p_write_clear;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == `CCT_OFF_FLAGS && reg_wdata[0] && is_capture(mode) && !capture_event)
      |=> !flag_q;
  endproperty
  a_write_clear: assert property (p_write_clear) else $error("flag not cleared by write");

  // a capture sets the flag even against any clear in that cycle
  property p_set_wins;
    @(posedge clock) disable iff (!reset_n)
      (active && is_capture(mode) && capture_event) |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat capture");
endmodule : cct_regs

// file: cct_defines.svh
// offsets, reset values and field positions for the counter/capture register tail
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH
`define CCT_OFF_FLAGS     4'h6
`define CCT_OFF_RUN_STATE 4'h7
`define CCT_OFF_DEBUG     4'h8
`define CCT_OFF_STAGING   4'h9
`define CCT_OFF_CNT_LO    4'hA
`define CCT_OFF_CNT_HI    4'hB
`define CCT_OFF_CAPTURE_COMPARE_VALUE_LO   4'hC
`define CCT_OFF_CAPTURE_COMPARE_VALUE_HI   4'hD
`define CCT_RST_BYTE      8'h00
`define CCT_RST_WORD      16'h0000
`define CCT_BIT_RUN       0
`define CCT_BIT_KEEP      0
`endif

// file: cct_pkg.sv
// types for the counter/capture register tail
package cct_pkg;
  // counter operating modes
  typedef enum logic [2:0] {
    CCT_MODE_PERIODIC = 3'h0,
    CCT_MODE_TIMEOUT  = 3'h1,
    CCT_MODE_CAPTURE_FLAG_EVT = 3'h2,
    CCT_MODE_CAPTURE_FLAG_FRQ = 3'h3,
    CCT_MODE_CAPTURE_FLAG_PW  = 3'h4,
    CCT_MODE_CAPTURE_FLAG_FPW = 3'h5,
    CCT_MODE_SINGLE   = 3'h6,
    CCT_MODE_PWM8     = 3'h7
  } cct_mode_t;
  // access state of the shared staging byte
  typedef enum logic [1:0] {
    CCT_ST_IDLE = 2'b01,
    CCT_ST_HELD = 2'b10
  } cct_stage_t;
endpackage : cct_pkg

// file: cct_cpu_model.sv
// cpu-side register bus model facing the counter/capture register tail
`timescale 1ns/100ps
module cct_cpu_model (
  // clock
  input  wire logic       clock,
  // register port
  output logic      [3:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr = 4'hF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one strobe cycle; released lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    @(posedge clock);
    #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
  // 16-bit write: low byte to staging first, high byte commits both
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, a, v[7:0], q);
    xfer(1'b1, a + 4'h1, v[15:8], q);
  endtask : wr16
  // 16-bit read: low byte first, high byte then comes from staging
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    xfer(1'b0, a, 8'h00, v[7:0]);
    xfer(1'b0, a + 4'h1, 8'h00, v[15:8]);
  endtask : rd16
endmodule : cct_cpu_model

// file: tb_cct_regs.sv
// self-checking bench for the counter/capture register tail
`timescale 1ns/100ps
module tb_cct_regs;
  logic               clock = 1'b0;
  logic               reset_n = 1'b0;
  logic [3:0]         reg_addr;
  logic               reg_wr, reg_rd, capture_flag, running, ok;
  logic [7:0]         reg_wdata, reg_rdata, q;
  cct_pkg::cct_mode_t mode = cct_pkg::CCT_MODE_PERIODIC;
  logic               enable = 1'b0, capture_event = 1'b0, cpu_halted = 1'b0, flag_clear = 1'b0;
  logic [15:0]        counter_out, v, e;
  logic [31:0]        seed = 32'h357D;
  int                 err_total = 0, total_checks = 0, i;
  // 50 MHz clock
  always #10 clock = ~clock;
  cct_regs i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode(mode), .enable(enable), .capture_event(capture_event),
    .cpu_halted(cpu_halted), .flag_clear(flag_clear), .capture_flag(capture_flag), .running(running),
    .counter_out(counter_out));
  cct_cpu_model i_cpu (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // xorshift source, fixed start so runs repeat
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  // run bit expected from enable, keep-going and halt
  function automatic logic exp_run(input logic en, input logic keep, input logic halt);
    return en & (keep | ~halt);
  endfunction : exp_run
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a);
    i_cpu.xfer(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_cpu.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    for (i = 7; i < 14; i++) begin
      rd(i[3:0]);
      chk(q, 16'h0000);
    end
    wr(4'h7, 8'hFF);
    rd(4'h7);
    chk(q, 16'h0000);
    $display("reset and run bit test done");
    // every mode once, halt from bit 0 and keep-going from bit 1 of the mode index
    for (i = 0; i < 8; i++) begin
      mode = cct_pkg::cct_mode_t'(i[2:0]);
      wr(4'h8, {7'h00, i[1]});
      cpu_halted = i[0];
      enable = 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(running, exp_run(1'b1, i[1], i[0]));
      v = counter_out;
      capture_event = 1'b1;
      @(posedge clock);
      #1 capture_event = 1'b0;
      if (i[0] && !i[1]) chk(counter_out, v);
      enable = 1'b0;
      cpu_halted = 1'b0;
    end
    rd(4'h8);
    chk(q, 16'h0001);
    $display("mode and debug test done");
    v = rnd();
    wr(4'h9, v[7:0]);
    rd(4'h9);
    chk(q, v[7:0]);
    i_cpu.wr16(4'hA, v);
    i_cpu.rd16(4'hA, e);
    chk(e, v);
    for (i = 0; i < 8; i++) begin
      v = rnd();
      i_cpu.wr16(4'hC, v);
      i_cpu.rd16(4'hC, e);
      chk(e, v);
    end
    // bus write against a running counter, then wrap at the top value
    mode = cct_pkg::CCT_MODE_PERIODIC;
    i_cpu.wr16(4'hC, 16'hFFFF);
    enable = 1'b1;
    v = rnd() & 16'h7FFF;
    i_cpu.wr16(4'hA, v);
    chk(counter_out, v);
    i_cpu.wr16(4'hC, 16'h0005);
    i_cpu.wr16(4'hA, 16'h0000);
    ok = 1'b1;
    repeat (20) @(posedge clock) #1 if (counter_out > 16'h0005) ok = 1'b0;
    chk(ok, 1'b1);
    $display("count and top test done");
    mode = cct_pkg::CCT_MODE_CAPTURE_FLAG_EVT;
    // top matches above left the flag set; clear it so the capture set is seen
    wr(4'h6, 8'h01);
    chk(capture_flag, 1'b0);
    @(posedge clock);
    #1 e = counter_out;
    capture_event = 1'b1;
    @(posedge clock);
    #1 capture_event = 1'b0;
    @(posedge clock);
    #1 chk(capture_flag, 1'b1);
    i_cpu.rd16(4'hC, v);
    chk(v, e);
    chk(capture_flag, 1'b0);
    // event and clear strobe together: the set wins
    capture_event = 1'b1;
    flag_clear = 1'b1;
    @(posedge clock);
    #1 capture_event = 1'b0;
    flag_clear = 1'b0;
    chk(capture_flag, 1'b1);
    wr(4'h6, 8'h01);
    chk(capture_flag, 1'b0);
    capture_event = 1'b1;
    @(posedge clock);
    #1 capture_event = 1'b0;
    flag_clear = 1'b1;
    chk(capture_flag, 1'b1);
    @(posedge clock);
    #1 flag_clear = 1'b0;
    chk(capture_flag, 1'b0);
    // a break with keep-going off drops events
    wr(4'h8, 8'h00);
    cpu_halted = 1'b1;
    capture_event = 1'b1;
    @(posedge clock);
    #1 capture_event = 1'b0;
    cpu_halted = 1'b0;
    enable = 1'b0;
    chk(capture_flag, 1'b0);
    $display("capture test done");
    // duty byte 3, period byte 9
    mode = cct_pkg::CCT_MODE_PWM8;
    i_cpu.wr16(4'hC, 16'h0309);
    i_cpu.wr16(4'hA, 16'h0000);
    enable = 1'b1;
    for (i = 0; i < 40 && capture_flag !== 1'b1; i++) @(posedge clock) #1;
    chk(capture_flag, 1'b1);
    chk(counter_out, 16'h0004);
    // period byte 9 bounds the count; a 16-bit top would let it climb past
    ok = 1'b1;
    repeat (30) @(posedge clock) #1 if (counter_out > 16'h0009) ok = 1'b0;
    chk(ok, 1'b1);
    $display("pwm test done");
    end_sim();
  end
  // hang guard
  initial begin
    #1000000;
    err_total++;
    end_sim();
  end
endmodule : tb_cct_regs
